//--- core/ddl_pkg.sv
package ddl_pkg;
  // Width of each converter code and of the shared shift register
  localparam int DATA_W = 12;
  // Preset codes applied while the preset input is held low
  localparam logic [11:0] MIDSCALE_CODE = 12'h800;
  localparam logic [11:0] ZERO_CODE = 12'h000;
  // Channel tag carried in the top bit of each update word
  localparam logic CHAN_A = 1'h0;
  localparam logic CHAN_B = 1'h1;
  // Update word is the channel tag above the code
  localparam int WORD_W = DATA_W + 1;
  localparam int WORD_CHAN_BIT = DATA_W;
  // Depth of the update queue towards the converter side
  localparam int FIFO_DEPTH = 8;
endpackage

//--- core/ddl_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module ddl_fifo #(
  parameter int WIDTH = ddl_pkg::WORD_W,
  parameter int DEPTH = ddl_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [PW:0] count_reg;
  logic push;
  logic pop;

  // Pointer step with wrap, so depths that are not powers of two work too
  function automatic logic [PW-1:0] ptr_step(input logic [PW-1:0] p);
    return (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  // Full and empty come straight from the occupancy count
  assign in_ready = (count_reg != (PW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data = mem[rd_ptr_reg];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Storage needs no reset; only entries below the count are ever read
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // Pointers and count
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= ptr_step(wr_ptr_reg);
      end
      if (pop) begin
        rd_ptr_reg <= ptr_step(rd_ptr_reg);
      end
      unique case ({push, pop})
        2'b10: count_reg <= count_reg + 1'b1;
        2'b01: count_reg <= count_reg - 1'b1;
        default: count_reg <= count_reg;
      endcase
    end
  end
endmodule
`default_nettype wire

//--- core/ddl_top.sv
// What this block does
// [RQ1] Shift one bit per serial clock rise, selected
// [RQ2] Shifted-in bit comes from serial data input
// [RQ3] Deselected: clock ignored; strobes unaffected by select
// [RQ4] Strobe A low: register A follows shift
// [RQ5] Strobe B low: register B follows shift
// [RQ6] Strobe fall updates register; shift untouched
// [RQ7] Preset low forces both registers, overrides all; here power-down low outranks the preset
// [RQ8] Midscale select high presets half-scale code
// [RQ9] Midscale select low presets zero code
// [RQ10] Power-down low freezes every register
// [RQ11] Host never shifts while a strobe low
// [RQ12] One shift register, two holding registers
// [RQ13] Twelve-bit shift and holding registers
// [RQ14] MSB first; last twelve bits are loaded
`timescale 1ns/100ps
`default_nettype none
module ddl_top #(
  parameter int FIFO_DEPTH = ddl_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic serial_clk,
  input wire logic chip_select_n,
  input wire logic serial_data_in,
  input wire logic load_strobe_a_n,
  input wire logic load_strobe_b_n,
  input wire logic async_preset_n,
  input wire logic midscale_sel,
  input wire logic power_down_n,
  input wire logic dac_word_ready,
  output logic [ddl_pkg::DATA_W-1:0] holding_a,
  output logic [ddl_pkg::DATA_W-1:0] holding_b,
  output logic [ddl_pkg::DATA_W-1:0] shift_value,
  output logic [ddl_pkg::WORD_W-1:0] dac_word_data,
  output logic dac_word_valid,
  output logic powered_down
);
  localparam int DW = ddl_pkg::DATA_W;
  localparam int WW = ddl_pkg::WORD_W;

  logic serial_clk_prev_reg;
  logic shift_event;
  logic [DW-1:0] shift_reg;
  logic [DW-1:0] shift_next;
  logic [DW-1:0] holding_a_reg;
  logic [DW-1:0] holding_a_next;
  logic [DW-1:0] holding_b_reg;
  logic [DW-1:0] holding_b_next;
  logic change_a;
  logic change_b;
  logic pending_a_reg;
  logic pending_b_reg;
  logic push_a;
  logic push_b;
  logic [WW-1:0] fifo_in_data;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic [WW-1:0] fifo_out_data;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [WW-1:0] word_data_reg;
  logic word_valid_reg;
  logic powered_down_reg;

  // Next value of one holding register; power-down outranks preset, preset outranks the strobe
  function automatic logic [DW-1:0] holding_step(
    input logic [DW-1:0] cur,
    input logic strobe_n,
    input logic [DW-1:0] shifted,
    input logic pd_n,
    input logic preset_n,
    input logic mid
  );
    logic [DW-1:0] val;
    val = cur;
    if (!pd_n) begin
      val = cur; // [RQ10]
    end else if (!preset_n) begin
      val = mid ? ddl_pkg::MIDSCALE_CODE : ddl_pkg::ZERO_CODE; // [RQ7] [RQ8] [RQ9]
    end else if (!strobe_n) begin
      val = shifted; // Transparent while low, so the rise leaves the last value
    end
    return val;
  endfunction

  // Serial clock is sampled as a plain synchronous input; its rise is found against the last sample
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      serial_clk_prev_reg <= 1'h0;
    end else begin
      serial_clk_prev_reg <= serial_clk;
    end
  end

  // Only a rise counts, only while selected and awake; levels never shift
  assign shift_event = serial_clk & ~serial_clk_prev_reg & ~chip_select_n & power_down_n; // [RQ1] [RQ3] [RQ10]

  // Shift toward the MSB, the newest bit enters at the LSB from the data pin
  assign shift_next = shift_event ? {shift_reg[DW-2:0], serial_data_in} : shift_reg; // [RQ1] [RQ2] [RQ14]

  // The one shared shift register; strobes and preset never touch it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      shift_reg <= ddl_pkg::ZERO_CODE;
    end else begin
      shift_reg <= shift_next; // [RQ6] [RQ12] [RQ13]
    end
  end

  // Holding registers follow the present shift value; a shift in the same cycle is the host's fault
  assign holding_a_next = holding_step(holding_a_reg, load_strobe_a_n, shift_reg, power_down_n,
                                       async_preset_n, midscale_sel); // [RQ4] [RQ6]
  assign holding_b_next = holding_step(holding_b_reg, load_strobe_b_n, shift_reg, power_down_n,
                                       async_preset_n, midscale_sel); // [RQ5] [RQ6]

  // Two separate holding registers, select has no path into them
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      holding_a_reg <= ddl_pkg::ZERO_CODE;
      holding_b_reg <= ddl_pkg::ZERO_CODE;
    end else begin
      holding_a_reg <= holding_a_next; // [RQ4] [RQ12]
      holding_b_reg <= holding_b_next; // [RQ5] [RQ12]
    end
  end

  assign change_a = (holding_a_next != holding_a_reg);
  assign change_b = (holding_b_next != holding_b_reg);

  // Channel A has priority; a queue stall only delays the report, never the register itself
  assign push_a = pending_a_reg & fifo_in_ready;
  assign push_b = pending_b_reg & ~pending_a_reg & fifo_in_ready;
  assign fifo_in_valid = pending_a_reg | pending_b_reg;
  assign fifo_in_data = pending_a_reg ? {ddl_pkg::CHAN_A, holding_a_reg} : {ddl_pkg::CHAN_B, holding_b_reg};

  // Pending flags coalesce changes; a change in the push cycle keeps the flag so the latest code follows
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pending_a_reg <= 1'h0;
      pending_b_reg <= 1'h0;
    end else begin
      pending_a_reg <= change_a | (pending_a_reg & ~push_a);
      pending_b_reg <= change_b | (pending_b_reg & ~push_b);
    end
  end

  ddl_fifo #(
    .WIDTH(WW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_b(rst_b),
    .in_data(fifo_in_data),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready)
  );

  // Output stage keeps the update port straight from flip-flops
  assign fifo_out_ready = ~word_valid_reg | dac_word_ready;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      word_valid_reg <= 1'h0;
      word_data_reg <= '0;
    end else if (fifo_out_ready) begin
      word_valid_reg <= fifo_out_valid;
      if (fifo_out_valid) begin
        word_data_reg <= fifo_out_data;
      end
    end
  end

  // Registered power-down status for the analog side
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      powered_down_reg <= 1'h0;
    end else begin
      powered_down_reg <= ~power_down_n; // [RQ10]
    end
  end

  assign holding_a = holding_a_reg;
  assign holding_b = holding_b_reg;
  assign shift_value = shift_reg;
  assign dac_word_data = word_data_reg;
  assign dac_word_valid = word_valid_reg;
  assign powered_down = powered_down_reg;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  property p_shift_advance;
    serial_clk && !serial_clk_prev_reg && !chip_select_n && power_down_n
      |=> shift_reg == {$past(shift_reg[DW-2:0]), $past(serial_data_in)};
  endproperty
  a_shift_advance: assert property (p_shift_advance) else $error("shift did not advance on clock rise"); // [RQ1] [RQ2]

  property p_shift_static;
    serial_clk == serial_clk_prev_reg |=> $stable(shift_reg);
  endproperty
  a_shift_static: assert property (p_shift_static) else $error("shift moved on a static clock"); // [RQ1]

  property p_deselect;
    chip_select_n |=> $stable(shift_reg);
  endproperty
  a_deselect: assert property (p_deselect) else $error("shift moved while deselected"); // [RQ3]

  property p_load_a;
    power_down_n && async_preset_n && !load_strobe_a_n |=> holding_a_reg == $past(shift_reg);
  endproperty
  a_load_a: assert property (p_load_a) else $error("register A did not follow shift"); // [RQ4]

  property p_latch_a;
    load_strobe_a_n && async_preset_n |=> $stable(holding_a_reg);
  endproperty
  a_latch_a: assert property (p_latch_a) else $error("register A changed while latched"); // [RQ4]

  property p_load_b;
    power_down_n && async_preset_n && !load_strobe_b_n |=> holding_b_reg == $past(shift_reg);
  endproperty
  a_load_b: assert property (p_load_b) else $error("register B did not follow shift"); // [RQ5]

  property p_latch_b;
    load_strobe_b_n && async_preset_n |=> $stable(holding_b_reg);
  endproperty
  a_latch_b: assert property (p_latch_b) else $error("register B changed while latched"); // [RQ5]

  property p_strobe_fall;
    $fell(load_strobe_a_n) && !shift_event |=> $stable(shift_reg);
  endproperty
  a_strobe_fall: assert property (p_strobe_fall) else $error("strobe disturbed the shift register"); // [RQ6]

  property p_strobe_fall_b;
    $fell(load_strobe_b_n) && !shift_event |=> $stable(shift_reg);
  endproperty
  a_strobe_fall_b: assert property (p_strobe_fall_b) else $error("strobe B disturbed shift"); // [RQ6]

  // Select gates only the serial clock; a deselected part must still load on its strobes
  property p_select_load_a;
    chip_select_n && power_down_n && async_preset_n && !load_strobe_a_n
      |=> holding_a_reg == $past(shift_reg);
  endproperty
  a_select_load_a: assert property (p_select_load_a) else $error("select blocked strobe A"); // [RQ3]

  property p_select_load_b;
    chip_select_n && power_down_n && async_preset_n && !load_strobe_b_n
      |=> holding_b_reg == $past(shift_reg);
  endproperty
  a_select_load_b: assert property (p_select_load_b) else $error("select blocked strobe B"); // [RQ3]

  property p_preset_mid;
    !async_preset_n && midscale_sel && power_down_n
      |=> holding_a_reg == ddl_pkg::MIDSCALE_CODE && holding_b_reg == ddl_pkg::MIDSCALE_CODE;
  endproperty
  a_preset_mid: assert property (p_preset_mid) else $error("half-scale preset missing"); // [RQ7] [RQ8]

  property p_preset_zero;
    !async_preset_n && !midscale_sel && power_down_n
      |=> holding_a_reg == ddl_pkg::ZERO_CODE && holding_b_reg == ddl_pkg::ZERO_CODE;
  endproperty
  a_preset_zero: assert property (p_preset_zero) else $error("zero preset missing"); // [RQ7] [RQ9]

  property p_power_down;
    !power_down_n |=> $stable(shift_reg) && $stable(holding_a_reg) && $stable(holding_b_reg);
  endproperty
  a_power_down: assert property (p_power_down) else $error("register changed in power-down"); // [RQ10]

  // Status flag trails the pin by one edge so the analog side sees a clean level
  property p_pd_flag_on;
    !power_down_n |=> powered_down_reg;
  endproperty
  a_pd_flag_on: assert property (p_pd_flag_on) else $error("power-down status not raised"); // [RQ10]

  property p_pd_flag_off;
    power_down_n |=> !powered_down_reg;
  endproperty
  a_pd_flag_off: assert property (p_pd_flag_off) else $error("power-down status not cleared"); // [RQ10]

  property p_report_pending;
    $changed(holding_a_reg) |-> pending_a_reg;
  endproperty
  a_report_pending: assert property (p_report_pending) else $error("change of register A not queued");

  property p_report_pending_b;
    $changed(holding_b_reg) |-> pending_b_reg;
  endproperty
  a_report_pending_b: assert property (p_report_pending_b) else $error("change of register B not queued");

  // At most one word per change: a pushed flag drops unless a newer change came in the same cycle
  property p_pending_a_clear;
    pending_a_reg && fifo_in_ready && !change_a |=> !pending_a_reg;
  endproperty
  a_pending_a_clear: assert property (p_pending_a_clear) else $error("word for register A queued twice");

  property p_pending_b_clear;
    pending_b_reg && !pending_a_reg && fifo_in_ready && !change_b |=> !pending_b_reg;
  endproperty
  a_pending_b_clear: assert property (p_pending_b_clear) else $error("word for register B queued twice");

  property p_word_hold;
    dac_word_valid && !dac_word_ready |=> dac_word_valid && $stable(dac_word_data);
  endproperty
  a_word_hold: assert property (p_word_hold) else $error("update word dropped under stall");
endmodule
`default_nettype wire

//--- test/ddl_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// Serial host: sends the low n_bits of word, one bit per serial clock rise
module ddl_host_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic deselect,
  input wire logic [15:0] word,
  input wire logic [4:0] n_bits,
  output logic serial_clk,
  output logic chip_select_n,
  output logic serial_data_in,
  output logic busy
);
  logic [4:0] left;
  logic phase;
  // Moves on the falling clk edge so every level is settled at the rising edge
  always_ff @(negedge clk or negedge rst_b) begin
    if (!rst_b) begin
      left <= 5'h00;
      phase <= 1'b0;
      serial_clk <= 1'b0;
      chip_select_n <= 1'b1;
      serial_data_in <= 1'b0;
      busy <= 1'b0;
    end else if (!busy) begin
      serial_clk <= 1'b0; // Clock stands still between frames
      chip_select_n <= 1'b1;
      serial_data_in <= ~serial_data_in; // Released line carries no stale bit
      if (start) begin
        busy <= 1'b1;
        left <= n_bits;
        phase <= 1'b0;
        chip_select_n <= deselect;
      end
    end else if (left == 5'h00) begin
      busy <= 1'b0;
    end else if (!phase) begin
      serial_clk <= 1'b0;
      serial_data_in <= word[left-1]; // MSB first
      phase <= 1'b1;
    end else begin
      serial_clk <= 1'b1;
      left <= left - 5'h01;
      phase <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- test/ddl_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
module ddl_top_tb;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic start = 1'b0;
  logic desel = 1'b0;
  logic [15:0] word = 16'h0000;
  logic [4:0] n_bits = 5'h0C;
  logic load_strobe_a_n = 1'b1;
  logic load_strobe_b_n = 1'b1;
  logic async_preset_n = 1'b1;
  logic midscale_sel = 1'b0;
  logic power_down_n = 1'b1;
  logic dac_word_ready = 1'b1;
  wire logic serial_clk, chip_select_n, serial_data_in, busy, dac_word_valid, powered_down;
  wire logic [11:0] holding_a, holding_b, shift_value;
  wire logic [12:0] dac_word_data;
  logic [12:0] w;
  logic [11:0] last_a, last_b;
  int n_mismatch = 0;
  int comparisons = 0;
  int i, k, n;
  always #2 clk = ~clk;
  ddl_host_model host (.clk(clk), .rst_b(rst_b), .start(start), .deselect(desel), .word(word),
    .n_bits(n_bits), .serial_clk(serial_clk), .chip_select_n(chip_select_n),
    .serial_data_in(serial_data_in), .busy(busy));
  ddl_top uut (.clk(clk), .rst_b(rst_b), .serial_clk(serial_clk), .chip_select_n(chip_select_n),
    .serial_data_in(serial_data_in), .load_strobe_a_n(load_strobe_a_n), .load_strobe_b_n(load_strobe_b_n),
    .async_preset_n(async_preset_n), .midscale_sel(midscale_sel), .power_down_n(power_down_n),
    .dac_word_ready(dac_word_ready), .holding_a(holding_a), .holding_b(holding_b),
    .shift_value(shift_value), .dac_word_data(dac_word_data), .dac_word_valid(dac_word_valid),
    .powered_down(powered_down));
  // Verdict and end of run, also reached when a wait runs out
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic bad(input string msg);
    $display("BAD %0t %s", $time, msg);
    n_mismatch++;
  endtask
  task automatic cmp_code(input logic [11:0] got, input logic [11:0] exp);
    comparisons++;
    if (got !== exp) bad($sformatf("code %h expected %h", got, exp));
  endtask
  task automatic cmp_word(input logic [12:0] got, input logic [12:0] exp);
    comparisons++;
    if (got !== exp) bad($sformatf("word %h expected %h", got, exp));
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) bad($sformatf("flag %b expected %b", got, exp));
  endtask
  // One host frame; returns once the host is idle again
  task automatic send(input logic [15:0] wd, input logic [4:0] nb, input logic ds);
    word = wd;
    n_bits = nb;
    desel = ds;
    start <= 1'b1;
    @(negedge clk);
    start <= 1'b0;
    @(negedge clk);
    for (i = 0; i < 100 && busy !== 1'b0; i++) @(negedge clk);
    if (busy !== 1'b0) begin
      bad("host frame hung");
      give_verdict();
    end
    @(negedge clk);
  endtask
  // Strobes only pulse while the host is idle, so nothing shifts meanwhile
  task automatic pulse(input logic a, input logic b);
    load_strobe_a_n = ~a;
    load_strobe_b_n = ~b;
    @(negedge clk);
    load_strobe_a_n = 1'b1;
    load_strobe_b_n = 1'b1;
    repeat (2) @(negedge clk);
  endtask
  // Preset with strobe A held low too, to show the preset wins
  task automatic preset(input logic mid);
    midscale_sel = mid;
    async_preset_n = 1'b0;
    load_strobe_a_n = 1'b0;
    repeat (2) @(negedge clk);
    async_preset_n = 1'b1;
    load_strobe_a_n = 1'b1;
    repeat (2) @(negedge clk);
  endtask
  // Waits for one update word and accepts it
  task automatic pop(output logic [12:0] wd);
    for (i = 0; i < 50 && dac_word_valid !== 1'b1; i++) @(negedge clk);
    if (dac_word_valid !== 1'b1) begin
      bad("no update word");
      give_verdict();
    end
    wd = dac_word_data;
    dac_word_ready = 1'b1;
    @(negedge clk);
    dac_word_ready = 1'b0;
  endtask
  // Main sequence
  initial begin
    repeat (4) @(negedge clk);
    rst_b = 1'b1;
    repeat (2) @(negedge clk);
    cmp_code(shift_value, 12'h000); // Reset value
    preset(1'b1);
    cmp_code(holding_a, ddl_pkg::MIDSCALE_CODE);
    cmp_code(holding_b, 12'h800);
    preset(1'b0);
    cmp_code(holding_a, 12'h000);
    cmp_code(holding_b, 12'h000);
    send(16'h0A5C, 5'h0C, 1'b0);
    cmp_code(shift_value, 12'hA5C);
    dac_word_ready = 1'b0;
    pulse(1'b1, 1'b0);
    cmp_code(holding_a, 12'hA5C);
    cmp_code(holding_b, 12'h000);
    cmp_code(shift_value, 12'hA5C);
    pop(w);
    cmp_word(w, {ddl_pkg::CHAN_A, 12'hA5C});
    send(16'h0FFF, 5'h0C, 1'b1);
    cmp_code(shift_value, 12'hA5C);
    send(16'hF3C7, 5'h10, 1'b0);
    cmp_code(shift_value, 12'h3C7);
    pulse(1'b0, 1'b1);
    cmp_code(holding_b, 12'h3C7);
    cmp_code(holding_a, 12'hA5C);
    pop(w);
    cmp_word(w, {ddl_pkg::CHAN_B, 12'h3C7});
    power_down_n = 1'b0;
    repeat (2) @(negedge clk);
    cmp_bit(powered_down, 1'b1);
    send(16'h0123, 5'h0C, 1'b0);
    pulse(1'b1, 1'b1);
    preset(1'b1);
    cmp_code(shift_value, 12'h3C7);
    cmp_code(holding_a, 12'hA5C);
    cmp_code(holding_b, 12'h3C7);
    power_down_n = 1'b1;
    repeat (2) @(negedge clk);
    cmp_bit(powered_down, 1'b0);
    // Twelve changes against a stalled sink overrun the queue; the latest codes must survive
    for (k = 0; k < 6; k++) preset(k[0]);
    dac_word_ready = 1'b1;
    n = 0;
    last_a = 12'hFFF;
    last_b = 12'hFFF;
    // Sample before waiting, so the word already standing in the output stage is counted too
    for (k = 0; k < 40; k++) begin
      if (dac_word_valid === 1'b1) begin
        n++;
        if (dac_word_data[ddl_pkg::WORD_CHAN_BIT] === ddl_pkg::CHAN_A) last_a = dac_word_data[11:0];
        else last_b = dac_word_data[11:0];
      end
      @(negedge clk);
    end
    // Queue plus output stage hold nine words, the two coalesced channels follow
    cmp_bit(n == ddl_pkg::FIFO_DEPTH + 3, 1'b1); // Queue filled, nothing duplicated
    cmp_code(last_a, ddl_pkg::MIDSCALE_CODE);
    cmp_code(last_b, ddl_pkg::MIDSCALE_CODE);
    give_verdict();
  end
endmodule
`default_nettype wire
